// ==== dv/stepper_link_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module stepper_link_properties (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link pin
   input wire logic standby,
   // bridge switches
   input wire logic aHighSwitchPlus,
   input wire logic aHighSwitchMinus,
   input wire logic aLowSwitchPlus,
   input wire logic aLowSwitchMinus,
   input wire logic bHighSwitchPlus,
   input wire logic bHighSwitchMinus,
   input wire logic bLowSwitchPlus,
   input wire logic bLowSwitchMinus,
   // status
   input wire logic chopStart,
   input wire logic standbyActive
);
   localparam int CHOP_GAP = stepper_chop_pkg::CHOP_DIVIDE * stepper_chop_pkg::OSC_DIVIDE - 1;
   logic [11:0] gap; // clocks since the last chop pulse
   logic seen; // low until a reference pulse exists
   wire [3:0] aSw = {aHighSwitchPlus, aHighSwitchMinus, aLowSwitchPlus, aLowSwitchMinus};
   wire [3:0] bSw = {bHighSwitchPlus, bHighSwitchMinus, bLowSwitchPlus, bLowSwitchMinus};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // gap counter; standby drops the reference since the chopper restarts
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         gap <= 12'h000;
         seen <= 1'b0;
      end
      else if (chopStart)
      begin
         gap <= 12'h000;
         seen <= 1'b1;
      end
      else
      begin
         gap <= gap + 12'h001;
         if (standbyActive)
            seen <= 1'b0;
      end
   end
   chk_a_pattern_legal:
   assert property (aSw inside {4'h0, 4'h9, 4'h3, 4'h6}) else $error("channel a bad pattern");
   chk_b_pattern_legal:
   assert property (bSw inside {4'h0, 4'h9, 4'h3, 4'h6}) else $error("channel b bad pattern");
   chk_standby_bridge_off:
   assert property (!standby [*6] |-> (aSw == 4'h0 && bSw == 4'h0)) else $error("bridge on in standby");
   chk_standby_flag_set:
   assert property (!standby [*4] |-> standbyActive) else $error("standby flag low");
   chk_standby_no_chop:
   assert property (standbyActive |-> !chopStart) else $error("chop pulse in standby");
   chk_chop_pulse_single:
   assert property (chopStart |=> !chopStart) else $error("chop pulse too long");
   chk_chop_gap_exact:
   assert property (chopStart && seen |-> gap == CHOP_GAP) else $error("chop period wrong");
   chk_chop_gap_bound:
   assert property (seen && !chopStart |-> gap < CHOP_GAP) else $error("chop pulse late");
endmodule : stepper_link_properties
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // stimulus
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic stepPulse = 1'b0;
   logic forward = 1'b1;
   logic [1:0] stepMode = 2'h0;
   logic supplyValid = 1'b0;
   logic enable = 1'b0;
   logic [9:0] aSenseCurrent = 10'h000;
   logic [9:0] bSenseCurrent = 10'h000;
   // design outputs
   logic [3:0] stepIndex;
   logic aHighSwitchPlus, aHighSwitchMinus, aLowSwitchPlus, aLowSwitchMinus;
   logic bHighSwitchPlus, bHighSwitchMinus, bLowSwitchPlus, bLowSwitchMinus;
   logic chopStart, standbyActive;
   // bench state; phase models the sequencer position in sixteenths
   int failures = 0;
   int comparisons = 0;
   int phase = 0;
   int n;
   // quarter table of channel a as {dir, hi, lo}; b runs twelve sixteenths ahead
   localparam logic [2:0] QTAB [16] = '{3'h6, 3'h5, 3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h3,
      3'h2, 3'h1, 3'h0, 3'h5, 3'h6, 3'h7, 3'h7, 3'h7};
   stepper_link_if linkBus ();
   wire [3:0] aSw = {aHighSwitchPlus, aHighSwitchMinus, aLowSwitchPlus, aLowSwitchMinus};
   wire [3:0] bSw = {bHighSwitchPlus, bHighSwitchMinus, bLowSwitchPlus, bLowSwitchMinus};
   wire [5:0] pins = {linkBus.aDirectionIn, linkBus.aLevelHi, linkBus.aLevelLo,
      linkBus.bDirectionIn, linkBus.bLevelHi, linkBus.bLevelLo};
   stepper_step_sequencer stepper_step_sequencer_inst (.clk(clk), .sys_rst(sys_rst),
      .stepPulse(stepPulse), .forward(forward), .stepMode(stepMode), .supplyValid(supplyValid),
      .enable(enable), .stepIndex(stepIndex), .link(linkBus));
   stepper_phase_chopper_ctrl stepper_phase_chopper_ctrl_inst (.clk(clk), .sys_rst(sys_rst),
      .link(linkBus), .aSenseCurrent(aSenseCurrent), .bSenseCurrent(bSenseCurrent),
      .aHighSwitchPlus(aHighSwitchPlus), .aHighSwitchMinus(aHighSwitchMinus),
      .aLowSwitchPlus(aLowSwitchPlus), .aLowSwitchMinus(aLowSwitchMinus),
      .bHighSwitchPlus(bHighSwitchPlus), .bHighSwitchMinus(bHighSwitchMinus),
      .bLowSwitchPlus(bLowSwitchPlus), .bLowSwitchMinus(bLowSwitchMinus),
      .chopStart(chopStart), .standbyActive(standbyActive));
   stepper_link_properties stepper_link_properties_inst (.clk(clk), .sys_rst(sys_rst),
      .standby(linkBus.standby), .aHighSwitchPlus(aHighSwitchPlus),
      .aHighSwitchMinus(aHighSwitchMinus), .aLowSwitchPlus(aLowSwitchPlus),
      .aLowSwitchMinus(aLowSwitchMinus), .bHighSwitchPlus(bHighSwitchPlus),
      .bHighSwitchMinus(bHighSwitchMinus), .bLowSwitchPlus(bLowSwitchPlus),
      .bLowSwitchMinus(bLowSwitchMinus), .chopStart(chopStart), .standbyActive(standbyActive));
   // 200 MHz clock
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   // expected channel code; zero level carries no direction
   function automatic logic [2:0] chanCode(input int mode, input int p);
      if (mode >= 2)
         return QTAB[p];
      if (mode == 1)
         return (p / 2 == 1 || p / 2 == 5) ? 3'h0 : {p / 2 == 0 || p / 2 >= 6, 2'h3};
      return {p / 4 == 0 || p / 4 == 3, 2'h3};
   endfunction : chanCode
   task automatic check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1)
      begin
         failures++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : check
   // link pins and phase against the model; low supply forces both levels to zero
   task automatic cmpLink();
      logic [5:0] e;
      logic [5:0] mask;
      e = {chanCode(stepMode, phase), chanCode(stepMode, (phase + 12) % 16)};
      if (!supplyValid)
         e = 6'h00;
      mask = {e[4:3] != 2'h0, 2'h3, e[1:0] != 2'h0, 2'h3};
      check((pins & mask) === e && stepIndex === 4'(phase), "link pins");
   endtask : cmpLink
   // model of the bridge pattern per state and polarity, order hp hm lp lm
   task automatic cmpSw(input stepper_chop_pkg::bridge_t st, input logic pos, input logic [3:0] got);
      logic [3:0] e;
      case (st)
         stepper_chop_pkg::CHARGE: e = pos ? 4'h9 : 4'h6;
         stepper_chop_pkg::SLOW: e = 4'h3;
         stepper_chop_pkg::FAST: e = pos ? 4'h6 : 4'h9;
         default: e = 4'h0;
      endcase
      check(got === e, "bridge switches");
   endtask : cmpSw
   task automatic cmpFlag(input logic got, input logic e);
      check(got === e, "status flag");
   endtask : cmpFlag
   // one step pulse; pins answer two edges later, so three cycles are allowed
   task automatic step(input logic fwd);
      int inc;
      inc = (stepMode == 2'h0) ? 4 : (stepMode == 2'h1) ? 2 : 1;
      @(negedge clk);
      forward = fwd;
      stepPulse = 1'b1;
      @(negedge clk);
      stepPulse = 1'b0;
      phase = (phase + (fwd ? inc : 16 - inc)) % 16;
      repeat (3) @(negedge clk);
   endtask : step
   // bounded wait for a chop start, then let the new target reach the switches
   task automatic waitChop();
      int k;
      k = 0;
      while (chopStart !== 1'b1 && k < 3000)
      begin
         @(negedge clk);
         k++;
      end
      check(k < 3000, "no chop start");
      repeat (5) @(negedge clk);
   endtask : waitChop
   // slow decay hands over to fast within the cycle
   task automatic waitFast(input logic pos);
      int k;
      k = 0;
      while (aSw === 4'h3 && k < 3000)
      begin
         @(negedge clk);
         k++;
      end
      cmpSw(stepper_chop_pkg::FAST, pos, aSw);
   endtask : waitFast
   task give_verdict();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : give_verdict
   // watchdog sized for about ten chop cycles plus margin
   initial
   begin
      #250000;
      failures++;
      give_verdict();
   end
   // main sequence
   initial
   begin
      void'($urandom(23738));
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
      cmpSw(stepper_chop_pkg::OFF, 1'b1, aSw | bSw);
      cmpFlag(standbyActive, 1'b1);
      $display("test reset done");
      enable = 1'b1;
      step(1'b1);
      cmpLink();
      supplyValid = 1'b1;
      for (int m = 0; m < 4; m++)
      begin
         stepMode = 2'(m);
         repeat (6)
         begin
            step(1'($urandom % 2));
            cmpLink();
         end
      end
      while (phase != 0)
         step(1'b1);
      cmpLink();
      $display("test stepping done");
      waitChop();
      cmpSw(stepper_chop_pkg::CHARGE, 1'b1, aSw);
      waitChop();
      cmpSw(stepper_chop_pkg::CHARGE, 1'b1, aSw);
      cmpSw(stepper_chop_pkg::CHARGE, 1'b1, bSw);
      waitChop();
      cmpSw(stepper_chop_pkg::CHARGE, 1'b1, aSw);
      aSenseCurrent = 10'h2c5;
      repeat (5) @(negedge clk);
      cmpSw(stepper_chop_pkg::CHARGE, 1'b1, aSw);
      aSenseCurrent = 10'h2c6;
      repeat (5) @(negedge clk);
      cmpSw(stepper_chop_pkg::SLOW, 1'b1, aSw);
      waitFast(1'b1);
      aSenseCurrent = 10'h295;
      waitChop();
      cmpSw(stepper_chop_pkg::FAST, 1'b1, aSw);
      aSenseCurrent = 10'h294;
      waitChop();
      cmpSw(stepper_chop_pkg::CHARGE, 1'b1, aSw);
      $display("test chopper done");
      repeat (4) step(1'b1);
      cmpLink();
      aSenseCurrent = 10'h000;
      waitChop();
      waitChop();
      cmpSw(stepper_chop_pkg::CHARGE, 1'b0, aSw);
      aSenseCurrent = 10'h2c6;
      repeat (5) @(negedge clk);
      cmpSw(stepper_chop_pkg::SLOW, 1'b0, aSw);
      waitFast(1'b0);
      repeat (2) step(1'b0);
      cmpLink();
      waitChop();
      waitChop();
      cmpSw(stepper_chop_pkg::OFF, 1'b1, aSw);
      $display("test polarity done");
      enable = 1'b0;
      repeat (8) @(negedge clk);
      cmpSw(stepper_chop_pkg::OFF, 1'b1, aSw | bSw);
      cmpFlag(standbyActive, 1'b1);
      n = 0;
      repeat (3000)
      begin
         @(negedge clk);
         if (chopStart === 1'b1)
            n++;
      end
      cmpFlag(n == 0, 1'b1);
      $display("test standby done");
      give_verdict();
   end
endmodule : testbench
`default_nettype wire

// ==== hw/stepper_phase_chopper_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - level bits pick 100, 71, 38 or 0 percent
// - direction high drives plus high, positive current
// - full step: four direction states at full scale
// - half step: reversing channel passes through zero
// - quarter step: sixteen states, B lags a quarter
// - standby low stops oscillator and bridge outputs
// - levels held low until motor supply valid
// - chopping timed from internal oscillator clock
// - chop cycle is sixteen oscillator periods
// - fixed mixed-decay threshold sets ripple band
// - charge extends past cycle until limit reached
// - reaching target ends charge, starts decay
// - fast decay extends until threshold reached
// - only charge, slow, fast and off bridge states
// - positive current switch pattern per state
// - negative current switch pattern per state
// - limit is level fraction of full scale
// - standby low resets all internal state but the input samplers
module stepper_phase_chopper_ctrl (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link from sequencer
   stepper_link_if.driver link,
   // sensed current per channel, per-mille of full scale
   input wire logic [9:0] aSenseCurrent,
   input wire logic [9:0] bSenseCurrent,
   // bridge switches channel A
   output logic aHighSwitchPlus,
   output logic aHighSwitchMinus,
   output logic aLowSwitchPlus,
   output logic aLowSwitchMinus,
   // bridge switches channel B
   output logic bHighSwitchPlus,
   output logic bHighSwitchMinus,
   output logic bLowSwitchPlus,
   output logic bLowSwitchMinus,
   // status
   output logic chopStart,
   output logic standbyActive
);
   // input samplers, two stages each (7 bits)
   logic [6:0] syncOne;
   logic [6:0] syncTwo;
   // oscillator enable divider and chop counter
   logic [7:0] oscCount;
   logic oscTick;
   logic [3:0] chopCount;
   logic cycleStart;
   logic running;
   // per-channel latched targets
   logic [9:0] aTarget;
   logic [9:0] bTarget;
   logic aSign;
   logic bSign;
   // target and sign in force this cycle: the fresh code at a boundary
   logic [9:0] aTargetNow;
   logic [9:0] bTargetNow;
   logic aSignNow;
   logic bSignNow;
   // per-channel bridge phase
   stepper_chop_pkg::bridge_t aState;
   stepper_chop_pkg::bridge_t bState;
   stepper_chop_pkg::bridge_t next_aState;
   stepper_chop_pkg::bridge_t next_bState;
   logic [3:0] next_aSw;
   logic [3:0] next_bSw;

   // level decode to per-mille of the full-scale limit
   function automatic logic [9:0] levelOf(input logic hi, input logic lo);
      logic [9:0] v;
      v = stepper_chop_pkg::LEVEL_ZERO;
      case ({hi, lo})
         2'h3: v = stepper_chop_pkg::LEVEL_FULL;
         2'h2: v = stepper_chop_pkg::LEVEL_71;
         2'h1: v = stepper_chop_pkg::LEVEL_38;
         default: v = stepper_chop_pkg::LEVEL_ZERO;
      endcase
      return v;
   endfunction : levelOf

   // next phase of one channel
   function automatic stepper_chop_pkg::bridge_t nextPhase(
      input stepper_chop_pkg::bridge_t cur, input logic start, input logic [3:0] cnt,
      input logic [9:0] target, input logic [9:0] sense);
      stepper_chop_pkg::bridge_t n;
      n = cur;
      case (cur)
         stepper_chop_pkg::CHARGE:
            if (sense >= target)
               n = stepper_chop_pkg::SLOW;
            else
               n = stepper_chop_pkg::CHARGE; // boundary ignored while charging
         stepper_chop_pkg::SLOW:
            if (start)
               n = stepper_chop_pkg::CHARGE;
            else if (cnt >= stepper_chop_pkg::SLOW_SPAN)
               n = stepper_chop_pkg::FAST;
         stepper_chop_pkg::FAST:
            // fast continues past boundary until at or below target minus band
            // one guard bit keeps a high sense reading from wrapping below target
            if (start && ({1'b0, sense} + {1'b0, stepper_chop_pkg::DECAY_BAND} <=
               {1'b0, target}))
               n = stepper_chop_pkg::CHARGE;
         default:
            if (start)
               n = stepper_chop_pkg::CHARGE;
      endcase
      if (target == stepper_chop_pkg::LEVEL_ZERO)
         n = stepper_chop_pkg::OFF; // zero level: bridge idle, direction ignored
      return n;
   endfunction : nextPhase

   // switch pattern {highPlus, highMinus, lowPlus, lowMinus}
   function automatic logic [3:0] switchesOf(input stepper_chop_pkg::bridge_t s,
      input logic positive);
      logic [3:0] w;
      w = 4'h0;
      case (s)
         stepper_chop_pkg::CHARGE: w = positive ? 4'h9 : 4'h6;
         stepper_chop_pkg::SLOW: w = 4'h3;
         stepper_chop_pkg::FAST: w = positive ? 4'h6 : 4'h9;
         default: w = 4'h0;
      endcase
      return w;
   endfunction : switchesOf

   // two-stage sampling of pins onto the one clock
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         syncOne <= 7'h00;
         syncTwo <= 7'h00;
      end
      else
      begin
         syncOne <= {link.standby, link.aDirectionIn, link.aLevelHi, link.aLevelLo,
            link.bDirectionIn, link.bLevelHi, link.bLevelLo};
         syncTwo <= syncOne;
      end
   end
   assign running = syncTwo[6];

   // oscillator modelled as an enable divider; halted in standby
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         oscCount <= 8'h00;
      else if (!running)
         oscCount <= 8'h00;
      else if (oscCount == 8'(stepper_chop_pkg::OSC_DIVIDE - 1))
         oscCount <= 8'h00;
      else
         oscCount <= oscCount + 8'h01;
   end
   assign oscTick = running && (oscCount == 8'(stepper_chop_pkg::OSC_DIVIDE - 1));

   // chop counter wraps every sixteen oscillator periods
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         chopCount <= 4'h0;
      else if (!running)
         chopCount <= 4'h0;
      else if (oscTick)
         chopCount <= chopCount + 4'h1;
   end
   assign cycleStart = oscTick && (chopCount == 4'(stepper_chop_pkg::CHOP_DIVIDE - 1));

   // latch new targets only at a cycle boundary
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         aTarget <= stepper_chop_pkg::LEVEL_ZERO;
         bTarget <= stepper_chop_pkg::LEVEL_ZERO;
         aSign <= 1'b0;
         bSign <= 1'b0;
      end
      else if (!running)
      begin
         aTarget <= stepper_chop_pkg::LEVEL_ZERO;
         bTarget <= stepper_chop_pkg::LEVEL_ZERO;
         aSign <= 1'b0;
         bSign <= 1'b0;
      end
      else if (cycleStart)
      begin
         aTarget <= levelOf(syncTwo[4], syncTwo[3]);
         bTarget <= levelOf(syncTwo[1], syncTwo[0]);
         aSign <= syncTwo[5];
         bSign <= syncTwo[2];
      end
   end

   // next phases and switch patterns; the boundary already uses the new target,
   // otherwise a step would wait a whole extra chop cycle
   always_comb
   begin
      aTargetNow = cycleStart ? levelOf(syncTwo[4], syncTwo[3]) : aTarget;
      bTargetNow = cycleStart ? levelOf(syncTwo[1], syncTwo[0]) : bTarget;
      aSignNow = cycleStart ? syncTwo[5] : aSign;
      bSignNow = cycleStart ? syncTwo[2] : bSign;
      next_aState = nextPhase(aState, cycleStart, chopCount, aTargetNow, aSenseCurrent);
      next_bState = nextPhase(bState, cycleStart, chopCount, bTargetNow, bSenseCurrent);
      next_aSw = switchesOf(next_aState, aSignNow);
      next_bSw = switchesOf(next_bState, bSignNow);
   end

   // bridge phase registers; standby clears to off
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         aState <= stepper_chop_pkg::OFF;
         bState <= stepper_chop_pkg::OFF;
      end
      else if (!running)
      begin
         aState <= stepper_chop_pkg::OFF;
         bState <= stepper_chop_pkg::OFF;
      end
      else
      begin
         aState <= next_aState;
         bState <= next_bState;
      end
   end

   // registered switch outputs, all off in standby
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         {aHighSwitchPlus, aHighSwitchMinus, aLowSwitchPlus, aLowSwitchMinus} <= 4'h0;
         {bHighSwitchPlus, bHighSwitchMinus, bLowSwitchPlus, bLowSwitchMinus} <= 4'h0;
         chopStart <= 1'b0;
         standbyActive <= 1'b1;
      end
      else
      begin
         {aHighSwitchPlus, aHighSwitchMinus, aLowSwitchPlus, aLowSwitchMinus} <=
            running ? next_aSw : 4'h0;
         {bHighSwitchPlus, bHighSwitchMinus, bLowSwitchPlus, bLowSwitchMinus} <=
            running ? next_bSw : 4'h0;
         chopStart <= cycleStart;
         standbyActive <= !running;
      end
   end
endmodule : stepper_phase_chopper_ctrl
`default_nettype wire

// ==== hw/stepper_step_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module stepper_step_sequencer (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // user side
   input wire logic stepPulse,
   input wire logic forward,
   input wire logic [1:0] stepMode,
   input wire logic supplyValid,
   input wire logic enable,
   output logic [3:0] stepIndex,
   // link to driver
   stepper_link_if.sequencer link
);
   // quarter-step phase in sixteenths of an electrical turn
   logic [3:0] phase;
   // stride: full 4, half 2, quarter 1
   logic [3:0] stride;
   logic [2:0] aCode;
   logic [2:0] bCode;
   always_comb
   begin
      case (stepMode)
         2'h0: stride = 4'h4;
         2'h1: stride = 4'h2;
         default: stride = 4'h1;
      endcase
   end
   // advance the phase on each step pulse; full steps sit on every fourth phase
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         phase <= 4'h0;
      else if (stepPulse && forward)
         phase <= phase + stride;
      else if (stepPulse)
         phase <= phase - stride;
   end
   // table of sign and level for one channel: bit2 dir, bits1:0 level
   function automatic logic [2:0] chanCode(input logic [3:0] p, input logic [1:0] mode);
      logic [2:0] c;
      c = 3'h0;
      case (p[2:0])
         3'h0: c = 3'h7;
         3'h1: c = 3'h7;
         3'h2: c = 3'h6;
         3'h3: c = 3'h5;
         3'h4: c = 3'h0;
         3'h5: c = 3'h1;
         3'h6: c = 3'h2;
         default: c = 3'h3;
      endcase
      if (p[3])
         c[2] = ~c[2];
      if (c[1:0] == 2'h0)
         c[2] = 1'b0;
      // full and half keep magnitude at full or zero; modes 2 and 3 are both quarter
      if (!mode[1] && c[1:0] != 2'h0)
         c[1:0] = 2'h3;
      return c;
   endfunction : chanCode
   // A leads, B lags a quarter turn: full step A+/B+,A-/B+,A-/B-,A+/B
   always_comb
   begin
      // offsets put phase 0 at +71/+71, so half steps land on the zero points
      aCode = chanCode(phase + 4'h2, stepMode);
      bCode = chanCode(phase + 4'he, stepMode);
   end
   // registered pins; levels forced low until supply valid
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         link.aDirectionIn <= 1'b0;
         link.bDirectionIn <= 1'b0;
         link.aLevelHi <= 1'b0;
         link.aLevelLo <= 1'b0;
         link.bLevelHi <= 1'b0;
         link.bLevelLo <= 1'b0;
         link.standby <= 1'b0;
         stepIndex <= 4'h0;
      end
      else
      begin
         link.aDirectionIn <= aCode[2];
         link.bDirectionIn <= bCode[2];
         link.aLevelHi <= supplyValid & aCode[1];
         link.aLevelLo <= supplyValid & aCode[0];
         link.bLevelHi <= supplyValid & bCode[1];
         link.bLevelLo <= supplyValid & bCode[0];
         link.standby <= enable;
         stepIndex <= phase;
      end
   end
endmodule : stepper_step_sequencer
`default_nettype wire

// ==== include/stepper_chop_pkg.sv ====
package stepper_chop_pkg;
   // chop cycle is the oscillator divided by this many periods
   localparam int unsigned CHOP_DIVIDE = 16;
   localparam int unsigned CHOP_COUNT_WIDTH = 4;
   // oscillator enable divider: system clocks per oscillator period
   localparam int unsigned OSC_DIVIDE = 179;
   localparam int unsigned OSC_COUNT_WIDTH = 8;
   // current target in per-mille of full scale
   localparam int unsigned LEVEL_WIDTH = 10;
   localparam logic [9:0] LEVEL_FULL = 10'h3e8;
   localparam logic [9:0] LEVEL_71 = 10'h2c6;
   localparam logic [9:0] LEVEL_38 = 10'h17c;
   localparam logic [9:0] LEVEL_ZERO = 10'h000;
   // fixed mixed-decay ripple band below target, per-mille, not adjustable
   localparam logic [9:0] DECAY_BAND = 10'h032;
   // chop counter position from which slow decay switches to fast
   localparam logic [3:0] SLOW_SPAN = 4'h8;
   // bridge phases
   typedef enum logic [1:0] {CHARGE, SLOW, FAST, OFF} bridge_t;
endpackage : stepper_chop_pkg

// ==== include/stepper_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface stepper_link_if;
   // direction per channel: high means positive current
   logic aDirectionIn;
   logic bDirectionIn;
   // two level bits per channel
   logic aLevelHi;
   logic aLevelLo;
   logic bLevelHi;
   logic bLevelLo;
   // high releases standby
   logic standby;
   modport sequencer (output aDirectionIn, bDirectionIn, aLevelHi, aLevelLo,
      bLevelHi, bLevelLo, standby);
   modport driver (input aDirectionIn, bDirectionIn, aLevelHi, aLevelLo,
      bLevelHi, bLevelLo, standby);
endinterface : stepper_link_if
`default_nettype wire
